// file: hdl/at_hdr_pkg.sv
package at_hdr_pkg;

   // apb register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_NODE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_COUNT = 8'h0C;

   // control register fields and reset value
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_RT_MODE_LSB = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [1:0] RT_MODE_FORWARD = 2'h0;
   localparam logic [1:0] RT_MODE_SINGLE = 2'h1;
   localparam logic [1:0] RT_MODE_DUAL = 2'h2;

   // node ident register: bus number 15:6, node number 5:0
   localparam int NODE_BUS_LSB = 6;
   localparam logic [15:0] NODE_RESET = 16'hFFFF;
   localparam logic [9:0] LOCAL_BUS_ALL_ONES = 10'h3FF;

   // control quadlet field positions
   localparam int Q0_SRC_BUS_BIT = 23;
   localparam int Q0_SPD_LSB = 16;
   localparam int Q0_TLABEL_LSB = 10;
   localparam int Q0_RT_LSB = 8;
   localparam int Q0_TCODE_LSB = 4;

   // transaction codes
   localparam logic [3:0] TC_WR_QUAD = 4'h0;
   localparam logic [3:0] TC_WR_BLOCK = 4'h1;
   localparam logic [3:0] TC_WR_RESP = 4'h2;
   localparam logic [3:0] TC_RD_QUAD = 4'h4;
   localparam logic [3:0] TC_RD_BLOCK = 4'h5;
   localparam logic [3:0] TC_RD_QUAD_RESP = 4'h6;
   localparam logic [3:0] TC_RD_BLOCK_RESP = 4'h7;
   localparam logic [3:0] TC_LOCK_REQ = 4'h9;
   localparam logic [3:0] TC_STREAM = 4'hA;
   localparam logic [3:0] TC_LOCK_RESP = 4'hB;
   localparam logic [3:0] TC_PHY = 4'hE;

   // retry codes
   localparam logic [1:0] RETRY_1 = 2'h0;
   localparam logic [1:0] RETRY_X = 2'h1;
   localparam logic [1:0] RETRY_A = 2'h2;
   localparam logic [1:0] RETRY_B = 2'h3;

   // internal quadlet counts per format
   localparam logic [2:0] LEN_NO_DATA = 3'h3;
   localparam logic [2:0] LEN_QUADLET = 3'h4;
   localparam logic [2:0] LEN_BLOCK = 3'h4;
   localparam logic [2:0] LEN_PHY = 3'h3;
   localparam logic [2:0] LEN_STREAM = 3'h2;

   typedef enum logic [2:0] {
      FMT_NO_DATA, FMT_QUADLET, FMT_BLOCK, FMT_PHY, FMT_STREAM, FMT_BAD
   } fmt_e;

   // one quadlet of the transmit stream
   typedef struct packed {
      logic [31:0] data;
      logic last;
   } quad_s;

endpackage

// file: hdl/hdr_word_store.sv
`timescale 1ns/1ps
`default_nettype none
module hdr_word_store (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [31:0] wr_data,
   // read port, data one cycle after address
   input wire logic [1:0] rd_addr,
   output logic [31:0] rd_data
);
   logic [31:0] mem [4];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= 32'h0000_0000;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // hdr_word_store
`default_nettype wire

// file: hdl/retry_phase_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module retry_phase_tracker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // acknowledge outcome of the last request sent
   input wire logic ack_busy_a,
   input wire logic ack_busy_b,
   input wire logic ack_done,
   // code for the next transmission
   output logic [1:0] retry_code
);
   // a fresh request starts as retry_1; busy phases steer the repeat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_code <= at_hdr_pkg::RETRY_1;
      end else if (ack_busy_a) begin
         retry_code <= at_hdr_pkg::RETRY_A;
      end else if (ack_busy_b) begin
         retry_code <= at_hdr_pkg::RETRY_B;
      end else if (ack_done) begin
         retry_code <= at_hdr_pkg::RETRY_1;
      end
   end
endmodule // retry_phase_tracker
`default_nettype wire

// file: hdl/async_request_header_former.sv
`timescale 1ns/1ps
`default_nettype none
module async_request_header_former (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // descriptor fetch side
   input wire logic in_valid,
   output logic in_ready,
   input wire at_hdr_pkg::quad_s in_quad,
   // link transmit side
   output logic out_valid,
   input wire logic out_ready,
   output at_hdr_pkg::quad_s out_quad,
   output logic [2:0] out_speed,
   output logic out_is_phy,
   // link status
   input wire logic async_period,
   input wire logic ack_busy_a,
   input wire logic ack_busy_b,
   input wire logic ack_done
);
   typedef enum logic [2:0] {
      S_IDLE, S_GATHER, S_DRAIN, S_READ, S_EMIT, S_PAYLOAD
   } state_e;

   state_e state;
   at_hdr_pkg::fmt_e fmt;
   logic [31:0] ctrl;
   logic [15:0] node_ident;
   logic [31:0] ctrl_q;
   logic [2:0] gather_idx;
   logic [2:0] wire_idx;
   logic last_seen;
   logic tcode_error;
   logic short_error;
   logic [15:0] sent_count;
   logic [1:0] rd_addr;
   logic [31:0] rd_data;
   logic [1:0] dual_rt;
   logic [1:0] rt_out;
   logic [9:0] src_bus;
   logic [15:0] source_ident;
   logic [2:0] need_len;
   logic [2:0] wire_len;
   logic [31:0] wire_word;
   logic in_fire;
   logic out_free;
   logic apb_wr;
   logic mapped;
   logic [3:0] tcode_in;
   at_hdr_pkg::fmt_e fmt_in;

   assign in_fire = in_valid && in_ready;
   assign out_free = !out_valid || out_ready;
   assign apb_wr = psel && penable && pwrite;
   assign tcode_in = in_quad.data[at_hdr_pkg::Q0_TCODE_LSB +: 4];

   // format from the tcode of the arriving control quadlet
   always_comb begin
      case (tcode_in)
         at_hdr_pkg::TC_RD_QUAD, at_hdr_pkg::TC_WR_RESP: fmt_in = at_hdr_pkg::FMT_NO_DATA;
         at_hdr_pkg::TC_WR_QUAD, at_hdr_pkg::TC_RD_BLOCK,
         at_hdr_pkg::TC_RD_QUAD_RESP: fmt_in = at_hdr_pkg::FMT_QUADLET;
         at_hdr_pkg::TC_WR_BLOCK, at_hdr_pkg::TC_RD_BLOCK_RESP,
         at_hdr_pkg::TC_LOCK_REQ, at_hdr_pkg::TC_LOCK_RESP: fmt_in = at_hdr_pkg::FMT_BLOCK;
         at_hdr_pkg::TC_PHY: fmt_in = at_hdr_pkg::FMT_PHY;
         at_hdr_pkg::TC_STREAM: fmt_in = at_hdr_pkg::FMT_STREAM;
         default: fmt_in = at_hdr_pkg::FMT_BAD;
      endcase
   end

   // internal quadlets to gather, wire quadlets to send
   always_comb begin
      case (fmt)
         at_hdr_pkg::FMT_NO_DATA: begin
            need_len = at_hdr_pkg::LEN_NO_DATA;
            wire_len = at_hdr_pkg::LEN_NO_DATA;
         end
         at_hdr_pkg::FMT_QUADLET: begin
            need_len = at_hdr_pkg::LEN_QUADLET;
            wire_len = at_hdr_pkg::LEN_QUADLET;
         end
         at_hdr_pkg::FMT_BLOCK: begin
            need_len = at_hdr_pkg::LEN_BLOCK;
            wire_len = at_hdr_pkg::LEN_BLOCK;
         end
         at_hdr_pkg::FMT_PHY: begin
            // control quadlet itself never reaches the wire
            need_len = at_hdr_pkg::LEN_PHY;
            wire_len = 3'(at_hdr_pkg::LEN_PHY - 3'h1);
         end
         at_hdr_pkg::FMT_STREAM: begin
            need_len = at_hdr_pkg::LEN_STREAM;
            wire_len = 3'h1;
         end
         default: begin
            need_len = 3'h1;
            wire_len = 3'h1;
         end
      endcase
   end

   // retry code selection
   always_comb begin
      case (ctrl[at_hdr_pkg::CTRL_RT_MODE_LSB +: 2])
         at_hdr_pkg::RT_MODE_SINGLE: rt_out = at_hdr_pkg::RETRY_X;
         at_hdr_pkg::RT_MODE_DUAL: rt_out = dual_rt;
         default: rt_out = ctrl_q[at_hdr_pkg::Q0_RT_LSB +: 2];
      endcase
   end

   assign src_bus = ctrl_q[at_hdr_pkg::Q0_SRC_BUS_BIT] ?
      node_ident[15:at_hdr_pkg::NODE_BUS_LSB] : at_hdr_pkg::LOCAL_BUS_ALL_ONES;
   assign source_ident = {src_bus, node_ident[at_hdr_pkg::NODE_BUS_LSB-1:0]};

   // word store address for each wire quadlet
   always_comb begin
      if (fmt == at_hdr_pkg::FMT_PHY) begin
         rd_addr = 2'(wire_idx + 3'h1);
      end else if (wire_idx == 3'h0) begin
         rd_addr = 2'h1;
      end else begin
         rd_addr = wire_idx[1:0];
      end
   end

   // wire quadlet from stored fields, reordered
   always_comb begin
      wire_word = rd_data;
      if (fmt == at_hdr_pkg::FMT_STREAM) begin
         wire_word = {rd_data[31:16], ctrl_q[15:10], rt_out, ctrl_q[7:0]};
      end else if (fmt != at_hdr_pkg::FMT_PHY) begin
         case (wire_idx)
            // label, tcode and reserved bits pass as given
            3'h0: wire_word = {rd_data[31:16], ctrl_q[15:10], rt_out, ctrl_q[7:0]};
            3'h1: wire_word = {source_ident, rd_data[15:0]};
            default: wire_word = rd_data;
         endcase
      end
   end

   hdr_word_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(in_fire && state == S_GATHER),
      .wr_addr(gather_idx[1:0]),
      .wr_data(in_quad.data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   retry_phase_tracker u_retry (
      .pclk(pclk),
      .presetn(presetn),
      .ack_busy_a(ack_busy_a),
      .ack_busy_b(ack_busy_b),
      .ack_done(ack_done),
      .retry_code(dual_rt)
   );

   // input acceptance; payload stalls on the output slot
   always_comb begin
      case (state)
         S_IDLE: in_ready = ctrl[at_hdr_pkg::CTRL_ENABLE_BIT];
         S_GATHER, S_DRAIN: in_ready = 1'b1;
         S_PAYLOAD: in_ready = out_free;
         default: in_ready = 1'b0;
      endcase
   end

   // packet sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         fmt <= at_hdr_pkg::FMT_BAD;
         ctrl_q <= 32'h0000_0000;
         gather_idx <= 3'h0;
         wire_idx <= 3'h0;
         last_seen <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (in_fire) begin
                  ctrl_q <= in_quad.data;
                  fmt <= fmt_in;
                  gather_idx <= 3'h1;
                  wire_idx <= 3'h0;
                  last_seen <= in_quad.last;
                  if (fmt_in == at_hdr_pkg::FMT_BAD) begin
                     state <= in_quad.last ? S_IDLE : S_DRAIN;
                  end else begin
                     state <= in_quad.last ? S_IDLE : S_GATHER;
                  end
               end
            end
            S_GATHER: begin
               if (in_fire) begin
                  gather_idx <= 3'(gather_idx + 3'h1);
                  last_seen <= in_quad.last;
                  if (3'(gather_idx + 3'h1) == need_len) begin
                     state <= S_READ;
                  end else if (in_quad.last) begin
                     state <= S_IDLE;
                  end
               end
            end
            S_DRAIN: begin
               // every quadlet up to the last is thrown away, extra or refused
               if (in_fire && in_quad.last) begin
                  state <= S_IDLE;
               end
            end
            S_READ: begin
               // stream waits for the asynchronous period
               if (fmt != at_hdr_pkg::FMT_STREAM || async_period) begin
                  state <= S_EMIT;
               end
            end
            S_EMIT: begin
               if (out_free) begin
                  wire_idx <= 3'(wire_idx + 3'h1);
                  if (3'(wire_idx + 3'h1) != wire_len) begin
                     state <= S_READ;
                  end else if (last_seen) begin
                     state <= S_IDLE;
                  end else if (fmt == at_hdr_pkg::FMT_BLOCK || fmt == at_hdr_pkg::FMT_STREAM) begin
                     state <= S_PAYLOAD;
                  end else begin
                     state <= S_DRAIN;
                  end
               end
            end
            S_PAYLOAD: begin
               if (in_fire && in_quad.last) begin
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // output slot, header words then payload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_quad <= '0;
         out_speed <= 3'h0;
         out_is_phy <= 1'b0;
      end else if (state == S_EMIT && out_free) begin
         out_valid <= 1'b1;
         out_quad.data <= wire_word;
         // header-only formats end on their final header word
         out_quad.last <= 3'(wire_idx + 3'h1) == wire_len && (last_seen
            || (fmt != at_hdr_pkg::FMT_BLOCK && fmt != at_hdr_pkg::FMT_STREAM));
         out_speed <= ctrl_q[at_hdr_pkg::Q0_SPD_LSB +: 3];
         out_is_phy <= fmt == at_hdr_pkg::FMT_PHY;
      end else if (state == S_PAYLOAD && in_fire) begin
         out_valid <= 1'b1;
         out_quad <= in_quad;
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

   // error flags: hardware set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcode_error <= 1'b0;
         short_error <= 1'b0;
      end else begin
         if (state == S_IDLE && in_fire && fmt_in == at_hdr_pkg::FMT_BAD) begin
            tcode_error <= 1'b1;
         end else if (apb_wr && paddr == at_hdr_pkg::OFF_STATUS && pwdata[0]) begin
            tcode_error <= 1'b0;
         end
         if (state == S_GATHER && in_fire && in_quad.last
             && 3'(gather_idx + 3'h1) != need_len) begin
            short_error <= 1'b1;
         end else if (apb_wr && paddr == at_hdr_pkg::OFF_STATUS && pwdata[1]) begin
            short_error <= 1'b0;
         end
      end
   end

   // count of headers sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sent_count <= 16'h0000;
      end else if (apb_wr && paddr == at_hdr_pkg::OFF_COUNT) begin
         sent_count <= 16'h0000;
      end else if (state == S_EMIT && out_free && wire_idx == 3'h0) begin
         sent_count <= 16'(sent_count + 16'h0001);
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= at_hdr_pkg::CTRL_RESET;
         node_ident <= at_hdr_pkg::NODE_RESET;
      end else if (apb_wr) begin
         if (paddr == at_hdr_pkg::OFF_CTRL) begin
            ctrl <= {29'h0, pwdata[2:0]};
         end
         if (paddr == at_hdr_pkg::OFF_NODE) begin
            node_ident <= pwdata[15:0];
         end
      end
   end

   // zero-wait apb slave; unmapped offsets report an error
   assign pready = 1'b1;
   always_comb begin
      mapped = paddr == at_hdr_pkg::OFF_CTRL || paddr == at_hdr_pkg::OFF_NODE
         || paddr == at_hdr_pkg::OFF_STATUS || paddr == at_hdr_pkg::OFF_COUNT;
      pslverr = psel && penable && !mapped;
   end

   always_comb begin
      case (paddr)
         at_hdr_pkg::OFF_CTRL: prdata = ctrl;
         at_hdr_pkg::OFF_NODE: prdata = {16'h0000, node_ident};
         at_hdr_pkg::OFF_STATUS: prdata = {25'h0, state != S_IDLE,
            fmt == at_hdr_pkg::FMT_STREAM, 1'b0, dual_rt, short_error, tcode_error};
         at_hdr_pkg::OFF_COUNT: prdata = {16'h0000, sent_count};
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule // async_request_header_former
`default_nettype wire

// file: verif/hdr_former_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hdr_former_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link side
   input wire logic out_valid,
   input wire logic out_ready,
   input wire at_hdr_pkg::quad_s out_quad,
   input wire logic [2:0] out_speed,
   input wire logic out_is_phy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_quad_held:
   assert property (out_valid && !out_ready |=> out_valid && $stable(out_quad))
      else $error("link word dropped or changed while stalled");
   a_speed_held:
   assert property (out_valid && !out_ready |=> $stable(out_speed) && $stable(out_is_phy))
      else $error("speed or phy flag changed while stalled");
   a_speed_frame:
   assert property (out_valid && out_ready && !out_quad.last |=> $stable(out_speed))
      else $error("speed changed inside a packet");
   a_last_gap:
   assert property (out_valid && out_ready && out_quad.last |=> !out_valid)
      else $error("word offered right after final word");
   a_reset_quiet:
   assert property ($rose(presetn) |-> !out_valid)
      else $error("link valid at reset release");
   a_bad_addr:
   assert property (psel && penable && paddr[7:4] != 4'h0 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_good_addr:
   assert property (psel && penable && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_zero_wait:
   assert property (psel && penable |-> pready)
      else $error("apb access stalled");
endmodule // hdr_former_checker
`default_nettype wire

// file: verif/link_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_tx_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link transmit side
   input wire logic out_valid,
   output logic out_ready,
   input wire at_hdr_pkg::quad_s out_quad,
   input wire logic [2:0] out_speed,
   input wire logic out_is_phy,
   // pacing from the bench
   input wire logic slow
);
   logic [1:0] tick;
   at_hdr_pkg::quad_s got[$];
   logic [2:0] got_spd;
   logic got_phy;
   // slow link takes one word in four, so held words get exercised
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         tick <= tick + 2'h1;
         out_ready <= !slow || tick == 2'h3;
         if (out_valid && out_ready) begin
            got.push_back(out_quad);
            got_spd <= out_speed;
            got_phy <= out_is_phy;
         end
      end
   end
endmodule // link_tx_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {
      logic [31:0] q0;
      logic [31:0] q1;
      logic [31:0] q2;
      logic [1:0] mode;
      logic four;
      logic slow;
   } row_s;
   localparam logic [15:0] NODE = 16'hA953;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic in_valid = 1'b0;
   logic in_ready;
   at_hdr_pkg::quad_s in_quad = '0;
   logic out_valid;
   logic out_ready;
   at_hdr_pkg::quad_s out_quad;
   logic [2:0] out_speed;
   logic out_is_phy;
   logic async_period = 1'b1;
   logic slow = 1'b0;
   logic ack_busy_a = 1'b0;
   logic ack_busy_b = 1'b0;
   logic ack_done = 1'b0;
   int errors = 0;
   int n_checks = 0;
   at_hdr_pkg::quad_s tx[$];
   at_hdr_pkg::quad_s ex[$];

   async_request_header_former uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
      .in_quad(in_quad), .out_valid(out_valid), .out_ready(out_ready), .out_quad(out_quad),
      .out_speed(out_speed), .out_is_phy(out_is_phy), .async_period(async_period),
      .ack_busy_a(ack_busy_a), .ack_busy_b(ack_busy_b), .ack_done(ack_done));
   link_tx_model link (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .out_ready(out_ready), .out_quad(out_quad), .out_speed(out_speed),
      .out_is_phy(out_is_phy), .slow(slow));

   always #25 pclk = ~pclk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic hang();
      errors++;
      $display("MISMATCH handshake expected done seen none");
      finish_test();
   endtask

   // request held until the rising edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
      if (k == 20) hang();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic send(input at_hdr_pkg::quad_s q[$]);
      int k;
      foreach (q[i]) begin
         in_valid <= 1'b1;
         in_quad <= q[i];
         @(posedge pclk);
         for (k = 0; k < 200 && in_ready !== 1'b1; k++) @(posedge pclk);
         if (k == 200) hang();
      end
      in_valid <= 1'b0;
   endtask

   task automatic expect_pkt(input string n, input at_hdr_pkg::quad_s x[$]);
      int k;
      for (k = 0; k < 400 && link.got.size() < x.size(); k++) @(posedge pclk);
      if (k == 400) hang();
      repeat (4) @(posedge pclk);
      chk({n, " count"}, 33'(x.size()), 33'(link.got.size()));
      foreach (x[i]) chk(n, x[i], link.got[i]);
      link.got.delete();
   endtask

   initial begin
      logic [31:0] r;
      logic e;
      logic [1:0] rt;
      logic [15:0] sid;
      row_s rows[3];
      rows = '{'{32'h0000_FD4F, 32'hFFC1_0000, 32'h1234_5678, 2'h0, 1'b0, 1'b0},
               '{32'h0081_0240, 32'h0A53_FFFF, 32'hFFFF_FFFC, 2'h0, 1'b1, 1'b1},
               '{32'h0082_5745, 32'h1234_0001, 32'h0000_0010, 2'h1, 1'b0, 1'b0}};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, at_hdr_pkg::OFF_CTRL, 32'h0, r, e);
      chk("ctrl reset", {1'b0, at_hdr_pkg::CTRL_RESET}, {1'b0, r});
      apb(1'b0, at_hdr_pkg::OFF_NODE, 32'h0, r, e);
      chk("node reset", {17'h0, at_hdr_pkg::NODE_RESET}, {1'b0, r});
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("unmapped error", 33'h1, {32'h0, e});
      apb(1'b1, at_hdr_pkg::OFF_NODE, {16'h0, NODE}, r, e);
      $display("test registers done");
      foreach (rows[i]) begin
         apb(1'b1, at_hdr_pkg::OFF_CTRL, {29'h0, rows[i].mode, 1'b1}, r, e);
         slow <= rows[i].slow;
         rt = rows[i].mode == at_hdr_pkg::RT_MODE_SINGLE ? at_hdr_pkg::RETRY_X : rows[i].q0[9:8];
         sid = {rows[i].q0[23] ? NODE[15:6] : at_hdr_pkg::LOCAL_BUS_ALL_ONES, NODE[5:0]};
         tx = '{'{rows[i].q0, 1'b0}, '{rows[i].q1, 1'b0}, '{rows[i].q2, !rows[i].four}};
         if (rows[i].four) tx.push_back('{32'hDEAD_BEEF, 1'b1});
         ex = '{'{{rows[i].q1[31:16], rows[i].q0[15:10], rt, rows[i].q0[7:0]}, 1'b0},
                '{{sid, rows[i].q1[15:0]}, 1'b0}, '{rows[i].q2, 1'b1}};
         send(tx);
         expect_pkt("no-data words", ex);
         chk("speed", {30'h0, rows[i].q0[18:16]}, {30'h0, link.got_spd});
      end
      apb(1'b0, at_hdr_pkg::OFF_COUNT, 32'h0, r, e);
      chk("header count", 33'h3, {1'b0, r});
      $display("test rows done");
      slow <= 1'b1;
      tx = '{'{32'h0001_0110, 1'b0}, '{32'hFFC2_0000, 1'b0}, '{32'h0000_0100, 1'b0},
             '{32'h0008_0000, 1'b0}, '{32'hCAFE_0001, 1'b0}, '{32'hCAFE_0002, 1'b1}};
      ex = '{'{32'hFFC2_0110, 1'b0}, '{32'hFFD3_0000, 1'b0}, '{32'h0000_0100, 1'b0},
             '{32'h0008_0000, 1'b0}, '{32'hCAFE_0001, 1'b0}, '{32'hCAFE_0002, 1'b1}};
      send(tx);
      expect_pkt("block words", ex);
      slow <= 1'b0;
      tx = '{'{32'h0000_00E0, 1'b0}, '{32'h0123_4567, 1'b0}, '{32'h89AB_CDEF, 1'b1}};
      send(tx);
      expect_pkt("phy words", tx[1:2]);
      chk("phy flag", 33'h1, {32'h0, link.got_phy});
      $display("test block and phy done");
      async_period <= 1'b0;
      tx = '{'{32'h0000_01A0, 1'b0}, '{32'h0004_0000, 1'b0}, '{32'h5555_AAAA, 1'b1}};
      ex = '{'{32'h0004_01A0, 1'b0}, '{32'h5555_AAAA, 1'b1}};
      // header must wait, so feed it from a side process
      fork
         send(tx);
      join_none
      repeat (20) @(posedge pclk);
      chk("stream held", 33'h0, 33'(link.got.size()));
      async_period <= 1'b1;
      expect_pkt("stream words", ex);
      $display("test stream done");
      tx = '{'{32'h0000_0130, 1'b0}, '{32'h0, 1'b0}, '{32'h0, 1'b1}};
      send(tx);
      @(posedge pclk);
      tx = '{'{32'h0000_0140, 1'b0}, '{32'h0, 1'b1}};
      send(tx);
      repeat (20) @(posedge pclk);
      chk("dropped", 33'h0, 33'(link.got.size()));
      apb(1'b0, at_hdr_pkg::OFF_STATUS, 32'h0, r, e);
      chk("status flags", 33'h3, {31'h0, r[1:0]});
      apb(1'b1, at_hdr_pkg::OFF_STATUS, 32'h3, r, e);
      apb(1'b0, at_hdr_pkg::OFF_STATUS, 32'h0, r, e);
      chk("status cleared", 33'h0, {31'h0, r[1:0]});
      $display("test refusals done");
      apb(1'b1, at_hdr_pkg::OFF_CTRL, {29'h0, at_hdr_pkg::RT_MODE_DUAL, 1'b1}, r, e);
      ack_busy_a <= 1'b1;
      @(posedge pclk);
      ack_busy_a <= 1'b0;
      tx = '{'{rows[0].q0, 1'b0}, '{rows[0].q1, 1'b0}, '{rows[0].q2, 1'b1}};
      ex = '{'{32'hFFC1_FE4F, 1'b0}, '{32'hFFD3_0000, 1'b0}, '{32'h1234_5678, 1'b1}};
      send(tx);
      expect_pkt("dual retry words", ex);
      ack_busy_b <= 1'b1;
      @(posedge pclk);
      ack_busy_b <= 1'b0;
      apb(1'b0, at_hdr_pkg::OFF_STATUS, 32'h0, r, e);
      chk("retry state", {31'h0, at_hdr_pkg::RETRY_B}, {31'h0, r[3:2]});
      $display("test dual retry done");
      finish_test();
   end
endmodule // tb_top

bind async_request_header_former hdr_former_checker chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready), .out_quad(out_quad),
   .out_speed(out_speed), .out_is_phy(out_is_phy));
`default_nettype wire
